// *** rtl/rblm_defs.svh ***
// How it works
// [RULE1] only enabled lanes change; others keep value
// [RULE2] write needs strobe; mask picks the lanes
// [RULE3] unused mask means all lanes enabled
// [RULE4] captured mask registers have no clear
// [RULE5] small block: widths 1 to 18, two-bit mask
// [RULE6] narrow widths masked only at full width
// [RULE7] narrow widths may gate by strobe instead
// [RULE8] small: bit 0 low lane, bit 1 upper
// [RULE9] medium: widths to 36, four-bit mask
// [RULE10] medium true dual narrow: assert bits 0,2
// [RULE11] large: widths 8 to 72, eight mask bits
// [RULE12] widest simple dual mode concatenates both masks
// [RULE13] widest mode: sixteen consecutive lanes, bit 15 top
// [RULE14] any mask pattern accepted, gaps allowed
// [RULE15] masked-off lane output undefined during write
// [RULE16] enabled lane output shows new data
// [RULE17] medium and large hold two packed memories
// [RULE18] packed memories run on one clock
// [RULE19] each packed half has own enables, clear
// [RULE20] every lane carries one extra parity bit; code adds it only at widths 9, 18, 36, 72, 144
// [RULE21] mask captured on same edge as write
`ifndef RBLM_DEFS_SVH
`define RBLM_DEFS_SVH

// --------------------------------------------------------------
// sizes
// --------------------------------------------------------------
`define RBLM_PORTS 2
`define RBLM_AW 6
`define RBLM_DEPTH 64
`define RBLM_WORD_W 144
`define RBLM_MASK_W 8
`define RBLM_LANES 16
`define RBLM_LANE_W 9
`define RBLM_SHIFT_W 8

// --------------------------------------------------------------
// mask values
// --------------------------------------------------------------
`define RBLM_MASK_ALL 8'hFF
`define RBLM_MASK_NONE 8'h00
`define RBLM_MASK_SMALL 8'h03
`define RBLM_MASK_MEDIUM 8'h0F
`define RBLM_MASK_LARGE 8'hFF
`define RBLM_MASK_TDP 8'h05
`define RBLM_LANE_ONES 9'h1FF

`endif

// *** rtl/rblm_pkg.sv ***
`default_nettype none

package rblm_pkg;

	typedef enum logic [1:0] {RBLM_SMALL, RBLM_MEDIUM, RBLM_LARGE} rblm_kind_t;

	typedef enum logic [1:0] {
		RBLM_SINGLE,
		RBLM_SIMPLE_DP,
		RBLM_TRUE_DP,
		RBLM_PACK
	} rblm_mode_t;

	typedef enum logic [3:0] {
		RBLM_W1, RBLM_W2, RBLM_W4, RBLM_W8, RBLM_W9,
		RBLM_W16, RBLM_W18, RBLM_W32, RBLM_W36,
		RBLM_W64, RBLM_W72, RBLM_W128, RBLM_W144
	} rblm_width_t;

	// bits per lane; narrow widths use the whole word as one lane
	function automatic logic [3:0] rblm_lane_bits(rblm_width_t w);
		case (w)
			RBLM_W1: return 4'h1;
			RBLM_W2: return 4'h2;
			RBLM_W4: return 4'h4;
			RBLM_W9, RBLM_W18, RBLM_W36, RBLM_W72, RBLM_W144: return 4'h9;
			default: return 4'h8;
		endcase
	endfunction

	function automatic logic [4:0] rblm_lane_count(rblm_width_t w);
		case (w)
			RBLM_W16, RBLM_W18: return 5'h02;
			RBLM_W32, RBLM_W36: return 5'h04;
			RBLM_W64, RBLM_W72: return 5'h08;
			RBLM_W128, RBLM_W144: return 5'h10;
			default: return 5'h01;
		endcase
	endfunction

	function automatic logic rblm_narrow(rblm_width_t w);
		return (w == RBLM_W1) || (w == RBLM_W2) || (w == RBLM_W4);
	endfunction

	function automatic logic rblm_fits(rblm_kind_t k, rblm_width_t w);
		case (k)
			RBLM_SMALL: return w <= RBLM_W18;
			RBLM_MEDIUM: return w <= RBLM_W36;
			RBLM_LARGE: return w >= RBLM_W8;
			default: return 1'b0;
		endcase
	endfunction

endpackage

`default_nettype wire

// *** rtl/rblm_if.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rblm_defs.svh"

interface rblm_if;
	rblm_pkg::rblm_kind_t kind;
	rblm_pkg::rblm_width_t width;
	rblm_pkg::rblm_mode_t mode;
	logic [`RBLM_PORTS-1:0] wr;
	logic [`RBLM_PORTS-1:0] ce;
	logic [`RBLM_PORTS-1:0] clr;
	logic [`RBLM_PORTS-1:0] mask_on;
	logic [`RBLM_MASK_W-1:0] mask [`RBLM_PORTS];
	logic [`RBLM_AW-1:0] addr [`RBLM_PORTS];
	logic [`RBLM_WORD_W-1:0] wdata [`RBLM_PORTS];
	logic [`RBLM_WORD_W-1:0] rdata [`RBLM_PORTS];

	modport dev (
		input kind, width, mode, wr, ce, clr, mask_on, mask, addr, wdata,
		output rdata
	);

	modport host (
		output kind, width, mode, wr, ce, clr, mask_on, mask, addr, wdata,
		input rdata
	);
endinterface

`default_nettype wire

// *** rtl/rblm_host.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rblm_defs.svh"

module rblm_host (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// memory side
	rblm_if.host mem,
	// configuration
	input wire rblm_pkg::rblm_kind_t kind_i,
	input wire rblm_pkg::rblm_width_t width_i,
	input wire rblm_pkg::rblm_mode_t mode_i,
	// per-port requests
	input wire logic [`RBLM_PORTS-1:0] wr_i,
	input wire logic [`RBLM_PORTS-1:0] ce_i,
	input wire logic [`RBLM_PORTS-1:0] clr_i,
	input wire logic [`RBLM_PORTS-1:0] mask_use_i,
	input wire logic [`RBLM_MASK_W-1:0] mask_i [`RBLM_PORTS],
	input wire logic [`RBLM_AW-1:0] addr_i [`RBLM_PORTS],
	input wire logic [`RBLM_WORD_W-1:0] wdata_i [`RBLM_PORTS],
	// read data
	output logic [`RBLM_WORD_W-1:0] rdata_o [`RBLM_PORTS]
);

	// --------------------------------------------------------------
	// configuration
	// --------------------------------------------------------------
	logic narrow;
	logic tdp_fix;

	assign narrow = rblm_pkg::rblm_narrow(width_i);
	assign tdp_fix = (mode_i == rblm_pkg::RBLM_TRUE_DP)
		&& (kind_i == rblm_pkg::RBLM_MEDIUM) && narrow;

	// both packed halves share core_clk_i, so single-clock holds [RULE18]
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mem.kind <= rblm_pkg::RBLM_SMALL;
			mem.width <= rblm_pkg::RBLM_W1;
			mem.mode <= rblm_pkg::RBLM_SINGLE;
		end
		else
		begin
			mem.kind <= kind_i;
			mem.width <= width_i;
			mem.mode <= mode_i;
		end
	end

	// --------------------------------------------------------------
	// per-port drive
	// --------------------------------------------------------------
	for (genvar p = 0; p < `RBLM_PORTS; p++)
	begin : g_port
		logic gate_by_wr;
		logic nxt_wr;
		logic nxt_mask_on;
		logic [`RBLM_MASK_W-1:0] nxt_mask;

		// narrow words cannot be split; outside medium true dual, bit 0 gates the strobe [RULE6] [RULE7]
		assign gate_by_wr = narrow && mask_use_i[p] && !tdp_fix;
		assign nxt_wr = wr_i[p] && (!gate_by_wr || mask_i[p][0]); // [RULE2]
		assign nxt_mask_on = (mask_use_i[p] && !narrow) || tdp_fix;
		assign nxt_mask = tdp_fix ? `RBLM_MASK_TDP : mask_i[p]; // [RULE10]

		always_ff @(posedge core_clk_i or negedge rstn_i)
		begin
			if (!rstn_i)
			begin
				mem.wr[p] <= 1'b0;
				mem.ce[p] <= 1'b0;
				mem.clr[p] <= 1'b0;
				mem.mask_on[p] <= 1'b0;
				mem.mask[p] <= `RBLM_MASK_NONE;
				mem.addr[p] <= '0;
				mem.wdata[p] <= '0;
				rdata_o[p] <= '0;
			end
			else
			begin
				mem.wr[p] <= nxt_wr;
				mem.ce[p] <= ce_i[p];
				mem.clr[p] <= clr_i[p];
				mem.mask_on[p] <= nxt_mask_on;
				mem.mask[p] <= nxt_mask;
				mem.addr[p] <= addr_i[p];
				mem.wdata[p] <= wdata_i[p];
				rdata_o[p] <= mem.rdata[p];
			end
		end
	end

endmodule // rblm_host

`default_nettype wire

// *** rtl/rblm_device.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rblm_defs.svh"

module rblm_device (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// memory side
	rblm_if.dev mem,
	// status
	output logic cfg_ok_o,
	output logic [`RBLM_PORTS-1:0] wr_done_o
);

	// --------------------------------------------------------------
	// configuration decode
	// --------------------------------------------------------------
	logic wide;
	logic cfg_ok;
	logic pack;
	logic [3:0] lane_bits;
	logic [4:0] lane_count;
	logic [`RBLM_LANE_W-1:0] lane_keep;
	logic [`RBLM_MASK_W-1:0] kind_mask;

	// 128/144 only exists as simple dual port of the large block
	assign wide = (mem.kind == rblm_pkg::RBLM_LARGE)
		&& ((mem.width == rblm_pkg::RBLM_W128)
		|| (mem.width == rblm_pkg::RBLM_W144));
	assign pack = (mem.mode == rblm_pkg::RBLM_PACK);

	// small has no true dual or packing; packing needs medium/large [RULE17]
	assign cfg_ok = rblm_pkg::rblm_fits(mem.kind, mem.width) // [RULE5] [RULE9] [RULE11]
		&& !(wide && (mem.mode != rblm_pkg::RBLM_SIMPLE_DP))
		&& !((mem.kind == rblm_pkg::RBLM_SMALL)
		&& ((mem.mode == rblm_pkg::RBLM_TRUE_DP) || pack));

	assign lane_bits = rblm_pkg::rblm_lane_bits(mem.width); // [RULE20]
	assign lane_count = rblm_pkg::rblm_lane_count(mem.width);
	assign lane_keep = `RBLM_LANE_ONES >> 4'(`RBLM_LANE_W - lane_bits);

	// mask bits beyond the block's own mask width are ignored
	assign kind_mask = (mem.kind == rblm_pkg::RBLM_SMALL) ? `RBLM_MASK_SMALL
		: (mem.kind == rblm_pkg::RBLM_MEDIUM) ? `RBLM_MASK_MEDIUM
		: `RBLM_MASK_LARGE; // [RULE5] [RULE9] [RULE11]

	// --------------------------------------------------------------
	// per-port input capture
	// --------------------------------------------------------------
	logic [`RBLM_PORTS-1:0] wr_ff;
	logic [`RBLM_PORTS-1:0] clr_ff;
	logic [`RBLM_PORTS-1:0] port_ok;
	logic [`RBLM_AW-1:0] addr_ff [`RBLM_PORTS];
	logic [`RBLM_AW-1:0] addr_eff [`RBLM_PORTS];
	logic [`RBLM_WORD_W-1:0] wdata_ff [`RBLM_PORTS];
	logic [`RBLM_MASK_W-1:0] mask_ff [`RBLM_PORTS];
	logic [`RBLM_LANES-1:0] mask16 [`RBLM_PORTS];
	logic [`RBLM_LANES-1:0] we [`RBLM_PORTS];

	// second port writes only as true dual or as the other packed half
	assign port_ok[0] = 1'b1;
	assign port_ok[1] = (mem.mode == rblm_pkg::RBLM_TRUE_DP) || pack;

	for (genvar p = 0; p < `RBLM_PORTS; p++)
	begin : g_cap
		logic nxt_wr;
		logic cap_ce;
		logic cap_on;
		logic [`RBLM_MASK_W-1:0] nxt_mask;
		logic [`RBLM_AW-1:0] nxt_addr;
		logic [`RBLM_WORD_W-1:0] nxt_wdata;

		// each half has its own clock enable and output clear [RULE19]
		assign nxt_wr = mem.wr[p] && mem.ce[p] && cfg_ok && port_ok[p]; // [RULE2]
		// widest mode: the upper mask rides on port 0's clock enable, since
		// port 1 never writes there [RULE12] [RULE21]
		assign cap_ce = (p == 1 && wide) ? mem.ce[0] : mem.ce[p];
		assign cap_on = (p == 1 && wide)
			? mem.mask_on[0] : mem.mask_on[p];
		assign nxt_mask = !cap_ce ? mask_ff[p]
			: cap_on ? mem.mask[p] : `RBLM_MASK_ALL; // [RULE3]
		assign nxt_addr = mem.ce[p] ? mem.addr[p] : addr_ff[p];
		assign nxt_wdata = mem.ce[p] ? mem.wdata[p] : wdata_ff[p];

		always_ff @(posedge core_clk_i or negedge rstn_i)
		begin
			if (!rstn_i)
			begin
				wr_ff[p] <= 1'b0;
				clr_ff[p] <= 1'b0;
			end
			else
			begin
				wr_ff[p] <= nxt_wr;
				clr_ff[p] <= mem.clr[p];
			end
		end

		// no clear on these: reset must not touch a captured mask
		always_ff @(posedge core_clk_i)
		begin
			mask_ff[p] <= nxt_mask; // [RULE4] [RULE21]
			addr_ff[p] <= nxt_addr;
			wdata_ff[p] <= nxt_wdata;
		end

		// a packed half sees only its own half of the array [RULE17] [RULE19]
		assign addr_eff[p] = pack
			? {1'(p), addr_ff[p][`RBLM_AW-2:0]} : addr_ff[p];
	end

	// --------------------------------------------------------------
	// lane enables
	// --------------------------------------------------------------
	// the widest mode takes its upper eight lanes from the second mask
	assign mask16[0] = wide ? {mask_ff[1], mask_ff[0]} // [RULE12] [RULE13]
		: {`RBLM_MASK_NONE, mask_ff[0] & kind_mask};
	assign mask16[1] = {`RBLM_MASK_NONE, mask_ff[1] & kind_mask};

	// narrow widths have one lane, so bit 0 covers the whole word
	for (genvar p = 0; p < `RBLM_PORTS; p++)
	begin : g_we
		for (genvar g = 0; g < `RBLM_LANES; g++)
		begin : g_lane
			// every pattern of bits is legal, gaps included [RULE14]
			assign we[p][g] = wr_ff[p] && mask16[p][g]
				&& (5'(g) < lane_count); // [RULE8] [RULE13]
		end
	end

	// --------------------------------------------------------------
	// lane storage
	// --------------------------------------------------------------
	logic [`RBLM_LANE_W-1:0] din [`RBLM_PORTS][`RBLM_LANES];
	logic [`RBLM_LANE_W-1:0] rd [`RBLM_PORTS][`RBLM_LANES];
	logic [`RBLM_LANE_W-1:0] qn [`RBLM_PORTS][`RBLM_LANES];

	for (genvar g = 0; g < `RBLM_LANES; g++)
	begin : g_mem
		logic [`RBLM_LANE_W-1:0] lane_mem [`RBLM_DEPTH];
		logic [`RBLM_SHIFT_W-1:0] shift;

		// lane g starts at g lane widths: 8 or 9 bits apart [RULE8] [RULE13]
		assign shift = `RBLM_SHIFT_W'(g * int'(lane_bits));

		for (genvar p = 0; p < `RBLM_PORTS; p++)
		begin : g_pt
			logic [`RBLM_WORD_W-1:0] shd;

			assign shd = wdata_ff[p] >> shift;
			assign din[p][g] = shd[`RBLM_LANE_W-1:0] & lane_keep;
			assign rd[p][g] = lane_mem[addr_eff[p]];
			// same-port read during write returns the new lane [RULE16]
			// a masked-off lane shows old contents; callers treat it
			// as undefined while writing [RULE15]
			assign qn[p][g] = we[p][g] ? din[p][g] : rd[p][g];
		end

		// on a same-address collision the first port wins
		always_ff @(posedge core_clk_i)
		begin
			if (we[1][g])
				lane_mem[addr_eff[1]] <= din[1][g]; // [RULE1]
			if (we[0][g])
				lane_mem[addr_eff[0]] <= din[0][g]; // [RULE1]
		end
	end

	// --------------------------------------------------------------
	// output registers
	// --------------------------------------------------------------
	for (genvar p = 0; p < `RBLM_PORTS; p++)
	begin : g_out
		logic [`RBLM_WORD_W-1:0] nxt_q;

		always_comb
		begin
			nxt_q = '0;
			for (int i = 0; i < `RBLM_LANES; i++)
			begin
				if (5'(i) < lane_count)
					nxt_q = nxt_q | (`RBLM_WORD_W'(qn[p][i] & lane_keep)
						<< (i * int'(lane_bits)));
			end
		end

		// output registers are the only ones the output clear zeroes [RULE19]
		always_ff @(posedge core_clk_i or negedge rstn_i)
		begin
			if (!rstn_i)
				mem.rdata[p] <= '0;
			else if (clr_ff[p])
				mem.rdata[p] <= '0;
			else
				mem.rdata[p] <= nxt_q;
		end
	end

	// --------------------------------------------------------------
	// status
	// --------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cfg_ok_o <= 1'b0;
			wr_done_o <= '0;
		end
		else
		begin
			cfg_ok_o <= cfg_ok;
			wr_done_o <= wr_ff;
		end
	end

endmodule // rblm_device

`default_nettype wire

// *** test/rblm_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rblm_defs.svh"

module rblm_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// link signals
	input wire rblm_pkg::rblm_kind_t kind,
	input wire rblm_pkg::rblm_width_t width,
	input wire rblm_pkg::rblm_mode_t mode,
	input wire logic [`RBLM_PORTS-1:0] wr,
	input wire logic [`RBLM_PORTS-1:0] ce,
	input wire logic [`RBLM_PORTS-1:0] clr,
	input wire logic [`RBLM_PORTS-1:0] mask_on,
	input wire logic [`RBLM_MASK_W-1:0] mask [`RBLM_PORTS],
	input wire logic [`RBLM_WORD_W-1:0] wdata [`RBLM_PORTS],
	input wire logic [`RBLM_WORD_W-1:0] rdata [`RBLM_PORTS],
	// device status
	input wire logic [`RBLM_PORTS-1:0] wr_done_o
);
	// configs the lane checks look at; others are left to the bench
	wire logic w0 = wr[0] && ce[0] && !clr[0];
	wire logic sg = mode == rblm_pkg::RBLM_SINGLE;
	wire logic s18 = sg && kind == rblm_pkg::RBLM_SMALL
		&& width == rblm_pkg::RBLM_W18;
	wire logic m36 = sg && kind == rblm_pkg::RBLM_MEDIUM
		&& width == rblm_pkg::RBLM_W36;
	wire logic l64 = sg && kind == rblm_pkg::RBLM_LARGE
		&& width == rblm_pkg::RBLM_W64;
	wire logic l72 = sg && kind == rblm_pkg::RBLM_LARGE
		&& width == rblm_pkg::RBLM_W72;
	wire logic wd = mode == rblm_pkg::RBLM_SIMPLE_DP
		&& kind == rblm_pkg::RBLM_LARGE && width == rblm_pkg::RBLM_W144;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	done_due_a: assert property (w0 && l72 |-> ##2 wr_done_o[0])
		else $error("write strobe gave no write");
	done_cause_a: assert property (
		wr_done_o[0] |-> $past(wr[0], 2) && $past(ce[0], 2))
		else $error("write done without strobe");
	port_refuse_a: assert property (wr_done_o[1] |->
		$past(mode, 2) inside {rblm_pkg::RBLM_TRUE_DP, rblm_pkg::RBLM_PACK})
		else $error("port 1 wrote in a read-only mode");
	full_word_a: assert property ((w0 && !mask_on[0] && l72)
		##1 !clr[0] |=> rdata[0][71:0] == $past(wdata[0][71:0], 2))
		else $error("unmasked write not whole word");
	lane_low_a: assert property ((w0 && mask_on[0] && mask[0][0] && s18)
		##1 !clr[0] |=> rdata[0][8:0] == $past(wdata[0][8:0], 2))
		else $error("small lane 0 not written");
	lane_upper_a: assert property ((w0 && mask_on[0] && mask[0][1] && s18)
		##1 !clr[0] |=> rdata[0][17:9] == $past(wdata[0][17:9], 2))
		else $error("small lane 1 not written");
	lane_mid_a: assert property ((w0 && mask_on[0] && mask[0][3] && m36)
		##1 !clr[0] |=> rdata[0][35:27] == $past(wdata[0][35:27], 2))
		else $error("medium lane 3 not written");
	lane_large_a: assert property ((w0 && mask_on[0] && mask[0][5] && l64)
		##1 !clr[0] |=> rdata[0][47:40] == $past(wdata[0][47:40], 2))
		else $error("large lane 5 not written");
	lane_top_a: assert property ((w0 && mask_on[0] && mask[1][7] && wd)
		##1 !clr[0] |=> rdata[0][143:135] == $past(wdata[0][143:135], 2))
		else $error("wide top lane not written");
endmodule // rblm_chk

`default_nettype wire

// *** test/tb_ram_byte_lane_write_mask.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rblm_defs.svh"

`define CHK(NM, E, S) begin num_checks++; if ((S) !== (E)) begin \
	mismatches++; $display("[FAIL] %s exp %h got %h", NM, E, S); end end

module tb_ram_byte_lane_write_mask;
	typedef struct {logic [143:0] e; logic [143:0] c; int p;} rblm_note_t;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	rblm_pkg::rblm_kind_t kind_i = rblm_pkg::RBLM_SMALL;
	rblm_pkg::rblm_width_t width_i = rblm_pkg::RBLM_W1;
	rblm_pkg::rblm_mode_t mode_i = rblm_pkg::RBLM_SINGLE;
	logic [1:0] wr_i = '0, ce_i = '0, clr_i = '0, use_i = '0;
	logic [7:0] mask_i [2] = '{8'h00, 8'h00};
	logic [5:0] addr_i [2] = '{6'h00, 6'h00};
	logic [143:0] wdata_i [2] = '{144'h0, 144'h0};
	logic [143:0] rdata_o [2];
	logic cfg_ok;
	logic [1:0] done;
	int mismatches = 0, num_checks = 0, cyc = 0;
	logic [31:0] seed = 32'h6DAF;
	logic [143:0] mdl [64], kn [64];
	rblm_note_t q [$];
	rblm_note_t n;
	logic [3:0] pipe = '0;
	logic chk = 1'b0;
	int lw_t [13] = '{1, 2, 4, 8, 9, 8, 9, 8, 9, 8, 9, 8, 9};
	int ln_t [13] = '{1, 1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16};
	// {kind, mode, width}: every lane width, count and port mode once
	logic [7:0] cf [14] = '{8'h06, 8'h00, 8'h01, 8'h02, 8'h48, 8'h63,
		8'h60, 8'h8A, 8'h89, 8'h9C, 8'h9B, 8'h75, 8'hA7, 8'h14};

	rblm_if mem_if ();
	rblm_host rblm_host_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.mem(mem_if), .kind_i(kind_i), .width_i(width_i), .mode_i(mode_i),
		.wr_i(wr_i), .ce_i(ce_i), .clr_i(clr_i), .mask_use_i(use_i),
		.mask_i(mask_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o));
	rblm_device rblm_device_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.mem(mem_if), .cfg_ok_o(cfg_ok), .wr_done_o(done));
	rblm_chk rblm_chk_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.kind(mem_if.kind), .width(mem_if.width), .mode(mem_if.mode),
		.wr(mem_if.wr), .ce(mem_if.ce), .clr(mem_if.clr),
		.mask_on(mem_if.mask_on), .mask(mem_if.mask), .wdata(mem_if.wdata),
		.rdata(mem_if.rdata), .wr_done_o(done));

	initial forever #4 core_clk_i = ~core_clk_i;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic end_sim();
		if (mismatches == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// --------------------------------------------------------------
	// one request on port p, expectation noted for the read side
	// --------------------------------------------------------------
	task automatic op(input int p, input logic w, input logic u,
		input logic c, input logic [5:0] a, input logic [15:0] m,
		input logic k);
		logic [143:0] d, bm;
		logic [15:0] mm;
		int ph, lw;
		logic wok;
		d = 144'({rnd(), rnd(), rnd(), rnd(), rnd()});
		ph = (mode_i == rblm_pkg::RBLM_PACK) ? {p[0], a[4:0]} : a;
		lw = lw_t[width_i];
		mm = p ? m >> 8 : m;
		bm = '0;
		for (int i = 0; i < ln_t[width_i]; i++)
			for (int b = 0; b < lw; b++)
				bm[i * lw + b] = !u || mm[i];
		wok = w && c && (p == 0 || mode_i inside
			{rblm_pkg::RBLM_TRUE_DP, rblm_pkg::RBLM_PACK});
		if (wok)
		begin
			mdl[ph] = (mdl[ph] & ~bm) | (d & bm);
			kn[ph] |= bm;
		end
		// masked-off lanes are undefined while written, so not compared
		// a cleared port shows all zeros, whatever was written
		if (c && k)
			q.push_back('{144'h0, {144{1'b1}}, p});
		else if (c)
			q.push_back('{mdl[ph], wok ? bm : kn[ph], p});
		wr_i = {1'b0, w} << p;
		ce_i = {1'b0, c} << p;
		clr_i = {1'b0, k} << p;
		use_i = {u, u};
		mask_i[0] = m[7:0];
		mask_i[1] = m[15:8];
		addr_i[p] = a;
		wdata_i[p] = d;
		chk = c;
		@(posedge core_clk_i);
		#1;
	endtask

	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		pipe <= {pipe[2:0], chk};
		if (cyc == 4000)
		begin
			mismatches++;
			end_sim();
		end
	end

	always @(negedge core_clk_i)
		if (pipe[3])
		begin
			n = q.pop_front();
			`CHK("rdata", n.e & n.c, rdata_o[n.p] & n.c)
		end

	initial
	begin
		logic [31:0] r;
		logic [15:0] m;
		logic wd;
		repeat (2) @(posedge core_clk_i);
		#1 rstn_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		foreach (cf[k])
		begin
			// let the last read leave the pipe before the layout changes
			chk = 1'b0;
			ce_i = '0;
			clr_i = '0;
			repeat (4) @(posedge core_clk_i);
			#1;
			kind_i = rblm_pkg::rblm_kind_t'(cf[k][7:6]);
			mode_i = rblm_pkg::rblm_mode_t'(cf[k][5:4]);
			width_i = rblm_pkg::rblm_width_t'(cf[k][3:0]);
			wd = cf[k][7:4] == 4'h9;
			repeat (3) @(posedge core_clk_i);
			#1;
			`CHK("cfg_ok", 1'b1, cfg_ok)
			foreach (kn[i])
				kn[i] = '0;
			for (int a = 0; a < 8; a++)
				op(0, 1'b1, 1'b0, 1'b1, 6'(a), 16'h0000, 1'b0);
			for (int i = 0; i < 40; i++)
			begin
				r = rnd();
				m = r[24:9];
				if (cf[k][7:4] == 4'h6 && cf[k][3:0] < 4'h5 && r[2])
					m = 16'h0505;
				op(int'(r[0] & ~wd), r[1], r[2], r[5:3] != 3'h0,
					6'(r[8:6]), m, r[31:29] == 3'h7);
			end
			for (int a = 0; a < 8; a++)
				op(0, 1'b0, 1'b0, 1'b1, 6'(a), 16'h0000, 1'b0);
		end
		chk = 1'b0;
		repeat (6) @(posedge core_clk_i);
		end_sim();
	end
endmodule // tb_ram_byte_lane_write_mask

`default_nettype wire
